//--- hdl/bpce_pkg.sv
package bpce_pkg;

  // ==========================================================
  // Register offsets (byte addresses on the register port)
  localparam logic [7:0] OFF_BG0 = 8'h00;
  localparam logic [7:0] OFF_BG1 = 8'h01;
  localparam logic [7:0] OFF_BG2 = 8'h02;
  localparam logic [7:0] OFF_BG3 = 8'h03;
  localparam logic [7:0] OFF_FG0 = 8'h04;
  localparam logic [7:0] OFF_FG1 = 8'h05;
  localparam logic [7:0] OFF_FG2 = 8'h06;
  localparam logic [7:0] OFF_FG3 = 8'h07;
  localparam logic [7:0] OFF_WID0 = 8'h08;
  localparam logic [7:0] OFF_WID1 = 8'h09;
  localparam logic [7:0] OFF_HGT0 = 8'h0A;
  localparam logic [7:0] OFF_HGT1 = 8'h0B;
  localparam logic [7:0] OFF_DPI0 = 8'h0C;
  localparam logic [7:0] OFF_DPI1 = 8'h0D;
  localparam logic [7:0] OFF_SPI0 = 8'h0E;
  localparam logic [7:0] OFF_SPI1 = 8'h0F;
  localparam logic [7:0] OFF_DST0 = 8'h10;
  localparam logic [7:0] OFF_DST1 = 8'h11;
  localparam logic [7:0] OFF_DST2 = 8'h12;
  localparam logic [7:0] OFF_SRC0 = 8'h14;
  localparam logic [7:0] OFF_SRC1 = 8'h15;
  localparam logic [7:0] OFF_SRC2 = 8'h16;
  localparam logic [7:0] OFF_CLIP = 8'h17;
  localparam logic [7:0] OFF_MODE = 8'h18;
  localparam logic [7:0] OFF_ROP = 8'h1A;
  localparam logic [7:0] OFF_EXT = 8'h1B;
  localparam logic [7:0] OFF_STAT = 8'h40;

  // ==========================================================
  // Field positions
  localparam int MODE_REV = 0;
  localparam int MODE_SYS = 2;
  localparam int MODE_TRANSP = 3;
  localparam int MODE_BPP_LSB = 4;
  localparam int MODE_PAT = 6;
  localparam int MODE_EXPAND = 7;
  localparam int EXT_DWORD_GRAN = 0;
  localparam int EXT_SOLID = 2;
  localparam int CLIP_SRC_LSB = 5;
  localparam int STAT_BUSY = 0;
  localparam int STAT_START = 1;
  localparam int STAT_RESET = 2;
  localparam int STAT_FLAG3 = 3;
  localparam int STAT_BUFFULL = 4;
  localparam int STAT_PAUSE = 5;
  localparam int STAT_AUTO = 7;

  // Packed-24 pixel size code
  localparam logic [1:0] BPP_24 = 2'h2;
  // Monochrome pattern size in bytes, minus one
  localparam logic [2:0] PAT_LAST = 3'h7;

  // ==========================================================
  // Parameter set, buffered and active copies
  typedef struct packed {
    logic [31:0] fg;
    logic [31:0] bg;
    logic [12:0] width;
    logic [10:0] height;
    logic [12:0] dpitch;
    logic [12:0] spitch;
    logic [21:0] dst;
    logic [21:0] src;
    logic [7:0] clip;
    logic [7:0] mode;
    logic [7:0] rop;
    logic [7:0] ext;
  } bpce_params_s;

  typedef enum logic [3:0] {
    S_IDLE,
    S_PATLD,
    S_PATWT,
    S_BYTE,
    S_RDWT,
    S_WRITE,
    S_WRWT,
    S_STEP,
    S_LINE
  } bpce_state_e;

endpackage : bpce_pkg

//--- hdl/bpce_sys_unpack.sv
`timescale 1ns/1ns
module bpce_sys_unpack
  import bpce_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic flush_i,
  input wire logic line_start_i,
  input wire logic [1:0] skip_i,
  input wire logic drop_i,
  // Host words
  input wire logic push_i,
  input wire logic [31:0] push_data_i,
  output logic push_rdy_o,
  // Bytes to engine
  input wire logic pop_i,
  output logic byte_vld_o,
  output logic [7:0] byte_o
);

  logic [31:0] word_q, word_d;
  logic [1:0] idx_q, idx_d;
  logic valid_q, valid_d;
  logic used_q, used_d;
  logic skip_pend_q, skip_pend_d;

  // ==========================================================
  // Next word state
  always_comb begin
    word_d = word_q;
    idx_d = idx_q;
    valid_d = valid_q;
    used_d = used_q;
    skip_pend_d = skip_pend_q | line_start_i;
    if (pop_i && valid_q) begin
      used_d = 1'b1;
      if (idx_q == 2'h3) begin
        valid_d = 1'b0;
      end else begin
        idx_d = idx_q + 2'h1;
      end
    end
    if (drop_i && valid_q && used_q) begin
      valid_d = 1'b0;
    end
    if (push_i && push_rdy_o) begin
      word_d = push_data_i;
      valid_d = 1'b1;
      used_d = 1'b0;
      idx_d = skip_pend_d ? skip_i : 2'h0;
      skip_pend_d = 1'b0;
    end
  end

  // ==========================================================
  // Word holding register
  always_ff @(posedge clk_i) begin
    if (rst_i || flush_i) begin
      word_q <= '0;
      idx_q <= 2'h0;
      valid_q <= 1'b0;
      used_q <= 1'b0;
      skip_pend_q <= line_start_i;
      push_rdy_o <= 1'b1;
    end else begin
      word_q <= word_d;
      idx_q <= idx_d;
      valid_q <= valid_d;
      used_q <= used_d;
      skip_pend_q <= skip_pend_d;
      push_rdy_o <= ~valid_d;
    end
  end

  assign byte_vld_o = valid_q;
  assign byte_o = word_q[{idx_q, 3'h0} +: 8];

endmodule : bpce_sys_unpack

//--- hdl/bpce_engine.sv
// Function
// - Skip first clip-count destination pixels per line
// - Packed-24 clip field five bits, byte count
// - Source skip picks first byte of line
// - Pattern mode reuses eight pixels, no pitch
// - Pattern size and alignment follow pixel depth
// - Packed-24 pattern rows padded to 32 bytes
// - Source low bits pick first pattern line
// - Cached mono pattern reused, line offset advances
// - Solid fill writes foreground, no pattern read
// - Reverse direction walks destination and src_addr source reads downward; pattern and expanded source reads still go upward
// - System source taken from host writes
// - Unused final-DWORD bytes dropped per line
// - Expanded lines drop bits or whole DWORD
// - Start bit launches, busy bit tracks transfer
// - Pause routes host writes straight to memory
// - Reset bit aborts after next write
// - Auto-start when idle and destination written
// - Buffer-full clear means parameters reloadable
`timescale 1ns/1ns
module bpce_engine
  import bpce_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // Register port
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  // Host display memory writes
  input wire logic HOST_WR_I,
  input wire logic [21:0] HOST_ADDR_I,
  input wire logic [31:0] HOST_WDATA_I,
  output logic HOST_WR_RDY_O,
  output logic DIRECT_WR_O,
  output logic [21:0] DIRECT_ADDR_O,
  output logic [31:0] DIRECT_DATA_O,
  // Display memory
  output logic MEM_REQ_O,
  output logic MEM_WE_O,
  output logic [21:0] MEM_ADDR_O,
  output logic [7:0] MEM_WDATA_O,
  input wire logic [7:0] MEM_RDATA_I,
  input wire logic MEM_ACK_I,
  // Status
  output logic BUSY_O
);

  bpce_params_s sh_q, act_q;
  bpce_state_e st_q;
  logic start_pend_q, pend_q, abort_q, pause_q, auto_q, flag3_q;
  logic cache_vld_q;
  logic [7:0] pcache_q [0:7];
  logic [2:0] yoff_q, row_q, bit_q, k_q;
  logic [12:0] x_q;
  logic [10:0] y_q;
  logic [21:0] ldst_q, lsrc_q, lin_q;
  logic [1:0] bip_q;
  logic [4:0] pcol_q;
  logic [7:0] cur_q;

  // ==========================================================
  // Decode and derived values
  logic stat_wr, reset_wr, go, routed;
  logic expand, pat, transp, sys, rev, solid, dgran;
  logic [1:0] bpp;
  logic [12:0] clip_bytes;
  logic [2:0] ssh;
  logic [4:0] rowlast;
  logic [21:0] pmask, pat_addr, src_addr, dst_addr;
  logic new_bit, needs_sys, pix_end, line_end, last_line;
  logic [7:0] mono, color, wr_data, ub_byte;
  logic pbit, suppress, ub_vld, ub_pop, ub_drop, ub_line, done;

  assign stat_wr = REG_WR_I && (REG_ADDR_I == OFF_STAT);
  assign reset_wr = stat_wr && REG_WDATA_I[STAT_RESET];
  assign go = (st_q == S_IDLE) && !abort_q && !reset_wr &&
              (start_pend_q || (auto_q && pend_q));
  assign expand = act_q.mode[MODE_EXPAND];
  assign pat = act_q.mode[MODE_PAT];
  assign transp = act_q.mode[MODE_TRANSP];
  assign sys = act_q.mode[MODE_SYS];
  assign rev = act_q.mode[MODE_REV];
  assign solid = act_q.ext[EXT_SOLID];
  assign dgran = act_q.ext[EXT_DWORD_GRAN];
  assign bpp = act_q.mode[MODE_BPP_LSB +: 2];
  assign clip_bytes = (bpp == BPP_24) ? {8'h00, act_q.clip[4:0]} :
                      {7'h00, 6'({3'h0, act_q.clip[2:0]} * ({4'h0, bpp} + 6'h01))};
  assign ssh = (bpp == 2'h0) ? 3'h3 : ((bpp == 2'h1) ? 3'h4 : 3'h5);
  assign rowlast = {bpp, 3'h7};
  assign pmask = 22'((22'h1 << ({1'b0, ssh} + 4'h3)) - 22'h1);
  assign pat_addr = 22'((act_q.src & ~pmask) + ({19'h0, row_q} << ssh) + {17'h0, pcol_q});
  assign src_addr = rev ? 22'(lsrc_q - {9'h0, x_q}) : 22'(lsrc_q + {9'h0, x_q});
  assign dst_addr = rev ? 22'(ldst_q - {9'h0, x_q}) : 22'(ldst_q + {9'h0, x_q});
  assign new_bit = (bit_q == 3'h0) && (bip_q == 2'h0);
  assign needs_sys = sys && (!expand || new_bit);
  assign pix_end = (bip_q == bpp);
  assign line_end = (x_q == act_q.width);
  assign last_line = (y_q == act_q.height);
  assign mono = solid ? 8'hFF : (pat ? pcache_q[row_q] : cur_q);
  assign pbit = mono[3'h7 - bit_q];
  assign color = pbit ? act_q.fg[{bip_q, 3'h0} +: 8] : act_q.bg[{bip_q, 3'h0} +: 8];
  assign wr_data = expand ? color : cur_q;
  assign suppress = (x_q < clip_bytes) || (expand && transp && !pbit);
  assign routed = BUSY_O && sys && !pause_q;
  assign ub_pop = (st_q == S_BYTE) && needs_sys && ub_vld;
  assign ub_drop = (st_q == S_LINE) && sys && (!expand || dgran);
  assign ub_line = go || (st_q == S_LINE);
  assign done = (st_q == S_LINE) && last_line;

  // ==========================================================
  // System source unpacker
  bpce_sys_unpack u_unpack (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .flush_i(go || reset_wr),
    .line_start_i(ub_line),
    .skip_i(act_q.clip[CLIP_SRC_LSB +: 2]),
    .drop_i(ub_drop),
    .push_i(HOST_WR_I && routed),
    .push_data_i(HOST_WDATA_I),
    .push_rdy_o(HOST_WR_RDY_O),
    .pop_i(ub_pop),
    .byte_vld_o(ub_vld),
    .byte_o(ub_byte)
  );

  // ==========================================================
  // Buffered parameter registers
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      sh_q <= '0;
    end else if (REG_WR_I) begin
      case (REG_ADDR_I)
        OFF_BG0: sh_q.bg[7:0] <= REG_WDATA_I;
        OFF_BG1: sh_q.bg[15:8] <= REG_WDATA_I;
        OFF_BG2: sh_q.bg[23:16] <= REG_WDATA_I;
        OFF_BG3: sh_q.bg[31:24] <= REG_WDATA_I;
        OFF_FG0: sh_q.fg[7:0] <= REG_WDATA_I;
        OFF_FG1: sh_q.fg[15:8] <= REG_WDATA_I;
        OFF_FG2: sh_q.fg[23:16] <= REG_WDATA_I;
        OFF_FG3: sh_q.fg[31:24] <= REG_WDATA_I;
        OFF_WID0: sh_q.width[7:0] <= REG_WDATA_I;
        OFF_WID1: sh_q.width[12:8] <= REG_WDATA_I[4:0];
        OFF_HGT0: sh_q.height[7:0] <= REG_WDATA_I;
        OFF_HGT1: sh_q.height[10:8] <= REG_WDATA_I[2:0];
        OFF_DPI0: sh_q.dpitch[7:0] <= REG_WDATA_I;
        OFF_DPI1: sh_q.dpitch[12:8] <= REG_WDATA_I[4:0];
        OFF_SPI0: sh_q.spitch[7:0] <= REG_WDATA_I;
        OFF_SPI1: sh_q.spitch[12:8] <= REG_WDATA_I[4:0];
        OFF_DST0: sh_q.dst[7:0] <= REG_WDATA_I;
        OFF_DST1: sh_q.dst[15:8] <= REG_WDATA_I;
        OFF_DST2: sh_q.dst[21:16] <= REG_WDATA_I[5:0];
        OFF_SRC0: sh_q.src[7:0] <= REG_WDATA_I;
        OFF_SRC1: sh_q.src[15:8] <= REG_WDATA_I;
        OFF_SRC2: sh_q.src[21:16] <= REG_WDATA_I[5:0];
        OFF_CLIP: sh_q.clip <= REG_WDATA_I;
        OFF_MODE: sh_q.mode <= REG_WDATA_I;
        OFF_ROP: sh_q.rop <= REG_WDATA_I;
        OFF_EXT: sh_q.ext <= REG_WDATA_I;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Active parameter copy
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      act_q <= '0;
    end else if (go) begin
      act_q <= sh_q;
    end
  end

  // ==========================================================
  // Start, status and control bits
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      start_pend_q <= 1'b0;
      pend_q <= 1'b0;
      abort_q <= 1'b0;
      pause_q <= 1'b0;
      auto_q <= 1'b0;
      flag3_q <= 1'b0;
    end else begin
      if (stat_wr && REG_WDATA_I[STAT_START]) begin
        start_pend_q <= 1'b1;
      end else if (go || abort_q) begin
        start_pend_q <= 1'b0;
      end
      if (REG_WR_I && (REG_ADDR_I >= OFF_DST0) && (REG_ADDR_I <= OFF_DST2)) begin
        pend_q <= 1'b1;
      end else if (go || abort_q) begin
        pend_q <= 1'b0;
      end
      if (reset_wr) begin
        abort_q <= 1'b1;
      end else if (st_q == S_IDLE) begin
        abort_q <= 1'b0;
      end
      if (stat_wr) begin
        pause_q <= REG_WDATA_I[STAT_PAUSE];
        auto_q <= REG_WDATA_I[STAT_AUTO];
        flag3_q <= REG_WDATA_I[STAT_FLAG3] && !REG_WDATA_I[STAT_RESET];
      end
    end
  end

  // ==========================================================
  // Pattern line offset and cache valid
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      yoff_q <= 3'h0;
      cache_vld_q <= 1'b0;
    end else begin
      if (REG_WR_I && (REG_ADDR_I == OFF_SRC0)) begin
        yoff_q <= REG_WDATA_I[2:0];
      end else if (done && expand && pat) begin
        yoff_q <= yoff_q + 3'h1;
      end
      if ((st_q == S_PATWT) && MEM_ACK_I && (k_q == PAT_LAST)) begin
        cache_vld_q <= 1'b1;
      end else if (reset_wr || (REG_WR_I && (((REG_ADDR_I >= OFF_SRC0) &&
                   (REG_ADDR_I <= OFF_SRC2)) || (REG_ADDR_I == OFF_MODE)))) begin
        cache_vld_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Register read back
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      REG_RDATA_O <= 8'h00;
    end else if (REG_RD_I) begin
      case (REG_ADDR_I)
        OFF_BG0: REG_RDATA_O <= sh_q.bg[7:0];
        OFF_BG1: REG_RDATA_O <= sh_q.bg[15:8];
        OFF_BG2: REG_RDATA_O <= sh_q.bg[23:16];
        OFF_BG3: REG_RDATA_O <= sh_q.bg[31:24];
        OFF_FG0: REG_RDATA_O <= sh_q.fg[7:0];
        OFF_FG1: REG_RDATA_O <= sh_q.fg[15:8];
        OFF_FG2: REG_RDATA_O <= sh_q.fg[23:16];
        OFF_FG3: REG_RDATA_O <= sh_q.fg[31:24];
        OFF_WID0: REG_RDATA_O <= sh_q.width[7:0];
        OFF_WID1: REG_RDATA_O <= {3'h0, sh_q.width[12:8]};
        OFF_HGT0: REG_RDATA_O <= sh_q.height[7:0];
        OFF_HGT1: REG_RDATA_O <= {5'h00, sh_q.height[10:8]};
        OFF_DPI0: REG_RDATA_O <= sh_q.dpitch[7:0];
        OFF_DPI1: REG_RDATA_O <= {3'h0, sh_q.dpitch[12:8]};
        OFF_SPI0: REG_RDATA_O <= sh_q.spitch[7:0];
        OFF_SPI1: REG_RDATA_O <= {3'h0, sh_q.spitch[12:8]};
        OFF_DST0: REG_RDATA_O <= sh_q.dst[7:0];
        OFF_DST1: REG_RDATA_O <= sh_q.dst[15:8];
        OFF_DST2: REG_RDATA_O <= {2'h0, sh_q.dst[21:16]};
        OFF_SRC0: REG_RDATA_O <= sh_q.src[7:0];
        OFF_SRC1: REG_RDATA_O <= sh_q.src[15:8];
        OFF_SRC2: REG_RDATA_O <= {2'h0, sh_q.src[21:16]};
        OFF_CLIP: REG_RDATA_O <= sh_q.clip;
        OFF_MODE: REG_RDATA_O <= sh_q.mode;
        OFF_ROP: REG_RDATA_O <= sh_q.rop;
        OFF_EXT: REG_RDATA_O <= sh_q.ext;
        OFF_STAT: REG_RDATA_O <= {auto_q, 1'b0, pause_q, pend_q && BUSY_O,
                                  flag3_q, 2'h0, BUSY_O};
        default: REG_RDATA_O <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Direct host writes when not feeding the engine
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      DIRECT_WR_O <= 1'b0;
      DIRECT_ADDR_O <= '0;
      DIRECT_DATA_O <= '0;
    end else begin
      DIRECT_WR_O <= HOST_WR_I && !routed;
      if (HOST_WR_I) begin
        DIRECT_ADDR_O <= HOST_ADDR_I;
        DIRECT_DATA_O <= HOST_WDATA_I;
      end
    end
  end

  // ==========================================================
  // Transfer sequencer
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      st_q <= S_IDLE;
      BUSY_O <= 1'b0;
      MEM_REQ_O <= 1'b0;
      MEM_WE_O <= 1'b0;
      MEM_ADDR_O <= '0;
      MEM_WDATA_O <= 8'h00;
      x_q <= '0;
      y_q <= '0;
      ldst_q <= '0;
      lsrc_q <= '0;
      lin_q <= '0;
      row_q <= 3'h0;
      bit_q <= 3'h0;
      bip_q <= 2'h0;
      pcol_q <= 5'h00;
      k_q <= 3'h0;
      cur_q <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        pcache_q[i] <= 8'h00;
      end
    end else begin
      case (st_q)
        S_IDLE: begin
          if (go) begin
            BUSY_O <= 1'b1;
            x_q <= '0;
            y_q <= '0;
            bit_q <= 3'h0;
            bip_q <= 2'h0;
            pcol_q <= 5'h00;
            k_q <= 3'h0;
            ldst_q <= sh_q.dst;
            lsrc_q <= sh_q.src;
            lin_q <= sh_q.src;
            row_q <= yoff_q;
            if (sh_q.mode[MODE_EXPAND] && sh_q.mode[MODE_PAT] &&
                !sh_q.ext[EXT_SOLID] && !cache_vld_q) begin
              st_q <= S_PATLD;
            end else begin
              st_q <= S_BYTE;
            end
          end
        end
        S_PATLD: begin
          MEM_REQ_O <= 1'b1;
          MEM_WE_O <= 1'b0;
          MEM_ADDR_O <= {act_q.src[21:3], k_q};
          st_q <= S_PATWT;
        end
        S_PATWT: begin
          if (MEM_ACK_I) begin
            MEM_REQ_O <= 1'b0;
            pcache_q[k_q] <= MEM_RDATA_I;
            k_q <= k_q + 3'h1;
            st_q <= (k_q == PAT_LAST) ? S_BYTE : S_PATLD;
          end
        end
        S_BYTE: begin
          if (needs_sys) begin
            if (ub_vld) begin
              cur_q <= ub_byte;
              st_q <= S_WRITE;
            end else if (abort_q) begin
              BUSY_O <= 1'b0;
              st_q <= S_IDLE;
            end
          end else if (expand) begin
            if (!pat && !solid && new_bit) begin
              MEM_REQ_O <= 1'b1;
              MEM_ADDR_O <= lin_q;
              lin_q <= 22'(lin_q + 22'h1);
              st_q <= S_RDWT;
            end else begin
              st_q <= S_WRITE;
            end
          end else begin
            MEM_REQ_O <= 1'b1;
            MEM_ADDR_O <= pat ? pat_addr : src_addr;
            st_q <= S_RDWT;
          end
        end
        S_RDWT: begin
          if (MEM_ACK_I) begin
            MEM_REQ_O <= 1'b0;
            cur_q <= MEM_RDATA_I;
            st_q <= S_WRITE;
          end
        end
        S_WRITE: begin
          if (suppress) begin
            st_q <= S_STEP;
          end else begin
            MEM_REQ_O <= 1'b1;
            MEM_WE_O <= 1'b1;
            MEM_ADDR_O <= dst_addr;
            MEM_WDATA_O <= wr_data;
            st_q <= S_WRWT;
          end
        end
        S_WRWT: begin
          if (MEM_ACK_I) begin
            MEM_REQ_O <= 1'b0;
            MEM_WE_O <= 1'b0;
            if (abort_q) begin
              BUSY_O <= 1'b0;
              st_q <= S_IDLE;
            end else begin
              st_q <= S_STEP;
            end
          end
        end
        S_STEP: begin
          if (abort_q) begin
            BUSY_O <= 1'b0;
            st_q <= S_IDLE;
          end else begin
            x_q <= 13'(x_q + 13'h1);
            bip_q <= pix_end ? 2'h0 : bip_q + 2'h1;
            bit_q <= pix_end ? bit_q + 3'h1 : bit_q;
            pcol_q <= (pcol_q == rowlast) ? 5'h00 : pcol_q + 5'h01;
            st_q <= line_end ? S_LINE : S_BYTE;
          end
        end
        S_LINE: begin
          if (last_line) begin
            BUSY_O <= 1'b0;
            st_q <= S_IDLE;
          end else begin
            y_q <= 11'(y_q + 11'h1);
            x_q <= '0;
            bit_q <= 3'h0;
            bip_q <= 2'h0;
            pcol_q <= 5'h00;
            row_q <= row_q + 3'h1;
            ldst_q <= rev ? 22'(ldst_q - {9'h0, act_q.dpitch}) :
                            22'(ldst_q + {9'h0, act_q.dpitch});
            lsrc_q <= rev ? 22'(lsrc_q - {9'h0, act_q.spitch}) :
                            22'(lsrc_q + {9'h0, act_q.spitch});
            st_q <= S_BYTE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

endmodule : bpce_engine

//--- dv/bpce_mem_model.sv
`timescale 1ns/1ns
module bpce_mem_model (
  // Clock, reset, speed
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  // Memory port
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [21:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic ack_o
);
  logic [7:0] mem [0:255];
  logic [1:0] wait_q;
  int rd_cnt;
  initial begin
    rd_cnt = 0;
    rdata_o = 8'h00;
    for (int i = 0; i < 256; i++) mem[i] = i[7:0];
  end
  // Read data only valid with ack
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (rst_i) begin
      wait_q <= 2'h0;
    end else if (req_i && !ack_o) begin
      if (wait_q == (slow_i ? 2'h3 : 2'h0)) begin
        ack_o <= 1'b1;
        wait_q <= 2'h0;
        if (we_i) mem[addr_i[7:0]] <= wdata_i;
        else rdata_o <= mem[addr_i[7:0]];
        if (!we_i) rd_cnt++;
      end else begin
        wait_q <= wait_q + 2'h1;
      end
    end
  end
endmodule : bpce_mem_model

//--- dv/bpce_engine_sva.sv
`timescale 1ns/1ns
module bpce_engine_sva
  import bpce_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic HOST_WR_I,
  input wire logic [21:0] HOST_ADDR_I,
  input wire logic DIRECT_WR_O,
  input wire logic [21:0] DIRECT_ADDR_O,
  input wire logic MEM_REQ_O,
  input wire logic MEM_WE_O,
  input wire logic [21:0] MEM_ADDR_O,
  input wire logic MEM_ACK_I,
  input wire logic BUSY_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  wire stat_wr = REG_WR_I && REG_ADDR_I == OFF_STAT;
  sequence s_start;
    stat_wr && REG_WDATA_I[STAT_START] && !REG_WDATA_I[STAT_RESET] && !BUSY_O;
  endsequence
  sequence s_wait;
    MEM_REQ_O && !MEM_ACK_I;
  endsequence
  a_req_hold: assert property (s_wait |=> MEM_REQ_O && $stable(MEM_ADDR_O)
    && $stable(MEM_WE_O)) else $error("memory request changed before ack");
  a_req_drop: assert property (MEM_REQ_O && MEM_ACK_I |=> !MEM_REQ_O)
    else $error("memory request held after ack");
  a_start_busy: assert property (s_start |-> ##2 BUSY_O)
    else $error("busy not raised after start");
  a_no_retrig: assert property ($fell(BUSY_O) |=> !BUSY_O)
    else $error("transfer retriggered");
  a_rd_status: assert property (REG_RD_I && REG_ADDR_I == OFF_STAT |=>
    REG_RDATA_O[0] == $past(BUSY_O) && REG_RDATA_O[2:1] == 2'h0)
    else $error("status read wrong");
  a_rd_unmap: assert property (REG_RD_I && REG_ADDR_I == 8'h13 |=> REG_RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  a_direct_idle: assert property (HOST_WR_I && !BUSY_O |=> DIRECT_WR_O
    && DIRECT_ADDR_O == $past(HOST_ADDR_I)) else $error("idle host write not direct");
  a_direct_only: assert property (!HOST_WR_I |=> !DIRECT_WR_O)
    else $error("direct write without host write");
  a_abort_stop: assert property (stat_wr && REG_WDATA_I[STAT_RESET] |->
    ##[1:40] !BUSY_O) else $error("abort did not stop");
endmodule : bpce_engine_sva
bind bpce_engine bpce_engine_sva i_bpce_engine_sva (.*);

//--- dv/bpce_engine_tb.sv
`timescale 1ns/1ns
module bpce_engine_tb
  import bpce_pkg::*;
;
  logic CLK_I, RST_I, REG_WR_I, REG_RD_I, HOST_WR_I, HOST_WR_RDY_O, DIRECT_WR_O;
  logic MEM_REQ_O, MEM_WE_O, MEM_ACK_I, BUSY_O, slow;
  logic [7:0] REG_ADDR_I, REG_WDATA_I, REG_RDATA_O, MEM_WDATA_O, MEM_RDATA_I, v;
  logic [21:0] HOST_ADDR_I, DIRECT_ADDR_O, MEM_ADDR_O;
  logic [31:0] HOST_WDATA_I, DIRECT_DATA_O;
  int errors, num_checks, cyc, rd0;
  bpce_engine i_bpce_engine (.*);
  bpce_mem_model i_bpce_mem_model (.clk_i(CLK_I), .rst_i(RST_I), .slow_i(slow),
    .req_i(MEM_REQ_O), .we_i(MEM_WE_O), .addr_i(MEM_ADDR_O), .wdata_i(MEM_WDATA_O),
    .rdata_o(MEM_RDATA_I), .ack_o(MEM_ACK_I));
  // ==========================================================
  // Bus tasks
  task stop_test;
    $display("errors=%0d checks=%0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  task chk(string n, logic [7:0] s, logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      $display("BAD %s exp %h got %h", n, e, s);
      errors++;
    end
  endtask : chk
  task wr(logic [7:0] a, logic [7:0] d);
    @(posedge CLK_I);
    REG_ADDR_I <= a;
    REG_WDATA_I <= d;
    REG_WR_I <= 1'b1;
    @(posedge CLK_I);
    REG_WR_I <= 1'b0;
  endtask : wr
  task rd(logic [7:0] a);
    @(posedge CLK_I);
    REG_ADDR_I <= a;
    REG_RD_I <= 1'b1;
    @(posedge CLK_I);
    REG_RD_I <= 1'b0;
    @(posedge CLK_I);
    v = REG_RDATA_O;
  endtask : rd
  task hw(logic [31:0] d);
    @(posedge CLK_I);
    HOST_WDATA_I <= d;
    HOST_WR_I <= 1'b1;
    do @(posedge CLK_I); while (HOST_WR_RDY_O !== 1'b1);
    HOST_WR_I <= 1'b0;
  endtask : hw
  task go(logic [7:0] s, logic [7:0] d, logic [7:0] w, logic [7:0] h, logic [7:0] m);
    wr(OFF_WID0, w);
    wr(OFF_HGT0, h);
    wr(OFF_SRC0, s);
    wr(OFF_MODE, m);
    wr(OFF_DST0, d);
    wr(OFF_STAT, 8'h02);
  endtask : go
  task idle;
    repeat (3) @(posedge CLK_I);
    while (BUSY_O !== 1'b0) @(posedge CLK_I);
  endtask : idle
  task mchk(logic [7:0] lo, logic [7:0] hi, logic [7:0] off, logic [3:0] f, logic [3:0] l);
    for (int a = lo; a <= hi; a++) begin
      v = a[7:0];
      chk("mem", i_bpce_mem_model.mem[a], (v[3:0] >= f && v[3:0] <= l) ? v - off : v);
    end
  endtask : mchk
  initial begin
    CLK_I = 1'b0;
    forever #20 CLK_I = ~CLK_I;
  end
  always @(posedge CLK_I) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      stop_test;
    end
  end
  // ==========================================================
  // Scenarios
  initial begin
    {REG_WR_I, REG_RD_I, HOST_WR_I, slow, REG_ADDR_I, REG_WDATA_I} = '0;
    HOST_ADDR_I = 22'h155;
    HOST_WDATA_I = '0;
    RST_I = 1'b1;
    repeat (10) @(posedge CLK_I);
    RST_I <= 1'b0;
    rd(OFF_STAT);
    chk("status", v, 8'h00);
    rd(8'h13);
    chk("unmapped", v, 8'h00);
    wr(OFF_DPI0, 8'h10);
    wr(OFF_SPI0, 8'h10);
    wr(OFF_CLIP, 8'h01);
    rd(OFF_CLIP);
    chk("clip", v, 8'h01);
    go(8'h20, 8'h80, 8'h03, 8'h01, 8'h00);
    idle();
    mchk(8'h80, 8'h9F, 8'h60, 4'h1, 4'h3);
    wr(OFF_CLIP, 8'h00);
    go(8'h33, 8'hC3, 8'h03, 8'h01, 8'h01);
    idle();
    mchk(8'hB0, 8'hC7, 8'h90, 4'h0, 4'h3);
    wr(OFF_FG0, 8'h5A);
    wr(OFF_EXT, 8'h04);
    rd0 = i_bpce_mem_model.rd_cnt;
    go(8'h00, 8'hD0, 8'h02, 8'h00, 8'hC0);
    idle();
    chk("reads", 8'(i_bpce_mem_model.rd_cnt - rd0), 8'h00);
    for (int a = 8'hD0; a < 8'hD4; a++)
      chk("solid", i_bpce_mem_model.mem[a], a < 8'hD3 ? 8'h5A : 8'hD3);
    wr(OFF_EXT, 8'h00);
    wr(OFF_STAT, 8'h80);
    wr(OFF_WID0, 8'h00);
    wr(OFF_SRC0, 8'h20);
    wr(OFF_MODE, 8'h00);
    wr(OFF_DST0, 8'hE0);
    idle();
    mchk(8'hE0, 8'hE1, 8'hC0, 4'h0, 4'h0);
    rd(OFF_STAT);
    chk("auto", v, 8'h80);
    wr(OFF_STAT, 8'h00);
    wr(OFF_BG0, 8'hA5);
    rd0 = i_bpce_mem_model.rd_cnt;
    go(8'h42, 8'hF0, 8'h07, 8'h00, 8'hC0);
    idle();
    wr(OFF_DST0, 8'hF8);
    wr(OFF_STAT, 8'h02);
    idle();
    chk("pat reads", 8'(i_bpce_mem_model.rd_cnt - rd0), 8'h08);
    for (int a = 0; a < 16; a++) begin
      v = (a < 8) ? 8'h42 : 8'h43;
      chk("pat", i_bpce_mem_model.mem[8'hF0 + a], v[~a[2:0]] ? 8'h5A : 8'hA5);
    end
    slow <= 1'b1;
    go(8'h00, 8'h60, 8'h04, 8'h01, 8'h04);
    hw(32'h13121110);
    hw(32'hEEEEEE14);
    hw(32'h23222120);
    hw(32'hEEEEEE24);
    idle();
    mchk(8'h60, 8'h77, 8'h50, 4'h0, 4'h4);
    go(8'h20, 8'h00, 8'h0F, 8'h3F, 8'h00);
    wr(OFF_STAT, 8'h08);
    wr(OFF_DST0, 8'h00);
    rd(OFF_STAT);
    chk("busy", v, 8'h19);
    wr(OFF_STAT, 8'h04);
    idle();
    rd(OFF_STAT);
    chk("aborted", v, 8'h00);
    hw(32'h000000A5);
    @(posedge CLK_I);
    chk("direct", DIRECT_DATA_O[7:0], 8'hA5);
    chk("direct wr", {7'h00, DIRECT_WR_O}, 8'h01);
    stop_test();
  end
endmodule : bpce_engine_tb
